/* File: logic/rfm_defines.svh */
// register offsets, field positions, reset values for the reference mask/config bank
`ifndef RFM_DEFINES_SVH
`define RFM_DEFINES_SVH
`define RFM_ADDR_WIDTH 7
`define RFM_OFS_FAIL_ISR 7'h02
`define RFM_OFS_FAIL_HIGH 7'h06
`define RFM_OFS_FAIL_LOW 7'h07
`define RFM_OFS_MASK_HIGH 7'h08
`define RFM_OFS_MASK_LOW 7'h09
`define RFM_OFS_INPUT_CFG 7'h0A
`define RFM_RST_MASK_LOW 8'h66
`define RFM_RST_MASK_HIGH 8'h66
`define RFM_RST_INPUT_CFG 8'h10
`define RFM_BIT_LOS 0
`define RFM_BIT_SCM 1
`define RFM_BIT_CFM 2
`define RFM_BIT_GST 3
`define RFM_CFG_HALVE_LSB 0
`define RFM_CFG_DIFF_LSB 4
`endif

/* File: logic/rfm_pkg.sv */
// types shared by the reference mask/config bank
package rfm_pkg;
	typedef logic [3:0] rfm_gate_t;
	typedef logic [7:0] rfm_byte_t;
	typedef enum logic [1:0] {
		RFM_IDLE = 2'b00,
		RFM_WRITE = 2'b01,
		RFM_READ = 2'b10
	} rfm_access_t;
endpackage

/* File: logic/rfm_input_path.sv */
// one reference input: receiver select and optional divide-by-2
`timescale 1ns/1ps
module rfm_input_path
	import rfm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// pins
	input wire logic positive_pin,
	input wire logic negative_pin,
	// configuration
	input wire logic halve_enable,
	input wire logic differential_select,
	// to loop
	output logic loop_ref
);
	logic pos_s1;
	logic pos_s2;
	logic neg_s1;
	logic neg_s2;
	logic rx_prev;
	logic half_clk;
	wire rx_level = differential_select ? (pos_s2 & ~neg_s2) : pos_s2;
	wire rx_rise = rx_level & ~rx_prev;

	always_ff @(posedge clk) begin
		pos_s1 <= positive_pin;
		pos_s2 <= pos_s1;
		neg_s1 <= negative_pin;
		neg_s2 <= neg_s1;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rx_prev <= 1'b0;
			half_clk <= 1'b0;
			loop_ref <= 1'b0;
		end else begin
			rx_prev <= rx_level;
			if (rx_rise)
				half_clk <= ~half_clk;
			loop_ref <= halve_enable ? half_clk : rx_level;
		end
	end

	a_half_toggle: assert property (@(posedge clk) disable iff (srst)
		$past(rx_rise) && !$past(srst) |-> half_clk != $past(half_clk))
		else $error("halver did not toggle on rising edge");
	a_path_select: assert property (@(posedge clk) disable iff (srst)
		!$past(srst) |-> loop_ref == ($past(halve_enable) ? $past(half_clk)
			: $past(rx_level)))
		else $error("loop reference path wrong");
endmodule // rfm_input_path

/* File: logic/rfm_bank.sv */
// reference failure mask and input configuration register bank
// Summary of operation
// - each reference has a 4-bit gate with bit 0 loss-of-signal, 1 single-cycle, 2 coarse-freq, 3 soak timer.
// - a gate bit of 0 disables its failure indicator and 1 enables it.
// - a cleared gate bit hides that failure from the interrupt status at address 0x02.
// - gate bits never touch the sticky raw failure bits, which record every failure.
// - one gate register holds references 2 and 3, the one at 0x09 holds references 0 and 1, low nibble first.
// - a set halve enable divides that input by 2 before its loop, else it passes undivided.
// - halve enables for references 0 to 3 sit in bits 0 to 3 of the input configuration register.
// - bits 4 to 7 pick differential (1) or single-ended positive-pin (0) reception per reference.
// - a sticky raw single-cycle bit is set on each such failure and stays set until cleared.
`timescale 1ns/1ps
`include "rfm_defines.svh"
module rfm_bank
	import rfm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [`RFM_ADDR_WIDTH-1:0] addr,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	output logic rd_valid,
	// failure events from monitors, one cycle pulses
	input wire logic [3:0] los_event,
	input wire logic [3:0] scm_event,
	input wire logic [3:0] cfm_event,
	input wire logic [3:0] gst_event,
	// reference pins
	input wire logic [3:0] input_positive_pin,
	input wire logic [3:0] input_negative_pin,
	// outputs
	output logic [3:0] loop_ref,
	output logic [3:0] ref_fail_status,
	output logic [3:0] input_halve_enable,
	output logic [3:0] input_differential_select
);
	// ****************************************
	// registers
	// ****************************************
	rfm_byte_t ref_fail_mask_low_pair;
	rfm_byte_t ref_fail_mask_high_pair;
	rfm_byte_t ref_input_config;
	rfm_byte_t raw_fail_low;
	rfm_byte_t raw_fail_high;

	function automatic rfm_byte_t pack_pair(input logic [3:0] l, s, c, g, input int r);
		pack_pair = {g[r+1], c[r+1], s[r+1], l[r+1], g[r], c[r], s[r], l[r]};
	endfunction

	function automatic logic gated_fail(input rfm_gate_t raw, input rfm_gate_t gate);
		gated_fail = |(raw & gate);
	endfunction

	// ****************************************
	// decode
	// ****************************************
	wire sel_mask_low = addr == `RFM_OFS_MASK_LOW;
	wire sel_mask_high = addr == `RFM_OFS_MASK_HIGH;
	wire sel_cfg = addr == `RFM_OFS_INPUT_CFG;
	wire sel_raw_low = addr == `RFM_OFS_FAIL_LOW;
	wire sel_raw_high = addr == `RFM_OFS_FAIL_HIGH;
	wire sel_isr = addr == `RFM_OFS_FAIL_ISR;
	wire rfm_byte_t ev_low = pack_pair(los_event, scm_event, cfm_event, gst_event, 0);
	wire rfm_byte_t ev_high = pack_pair(los_event, scm_event, cfm_event, gst_event, 2);
	wire rfm_byte_t clr_low = (wr_en && sel_raw_low) ? wr_data : 8'h00;
	wire rfm_byte_t clr_high = (wr_en && sel_raw_high) ? wr_data : 8'h00;
	// set wins over clear; gates play no part here
	wire rfm_byte_t next_raw_low = (raw_fail_low & ~clr_low) | ev_low;
	wire rfm_byte_t next_raw_high = (raw_fail_high & ~clr_high) | ev_high;
	wire rfm_gate_t gate0 = ref_fail_mask_low_pair[3:0];
	wire rfm_gate_t gate1 = ref_fail_mask_low_pair[7:4];
	wire rfm_gate_t gate2 = ref_fail_mask_high_pair[3:0];
	wire rfm_gate_t gate3 = ref_fail_mask_high_pair[7:4];
	wire [3:0] next_status = {gated_fail(raw_fail_high[7:4], gate3),
		gated_fail(raw_fail_high[3:0], gate2),
		gated_fail(raw_fail_low[7:4], gate1),
		gated_fail(raw_fail_low[3:0], gate0)};
	wire rfm_byte_t next_rd_data = sel_mask_low ? ref_fail_mask_low_pair
		: sel_mask_high ? ref_fail_mask_high_pair
		: sel_cfg ? ref_input_config
		: sel_raw_low ? raw_fail_low
		: sel_raw_high ? raw_fail_high
		: sel_isr ? {4'h0, ref_fail_status}
		: 8'h00;

	assign input_halve_enable = ref_input_config[`RFM_CFG_HALVE_LSB +: 4];
	assign input_differential_select = ref_input_config[`RFM_CFG_DIFF_LSB +: 4];

	// ****************************************
	// storage
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			ref_fail_mask_low_pair <= `RFM_RST_MASK_LOW;
			ref_fail_mask_high_pair <= `RFM_RST_MASK_HIGH;
			ref_input_config <= `RFM_RST_INPUT_CFG;
		end else if (wr_en) begin
			if (sel_mask_low)
				ref_fail_mask_low_pair <= wr_data;
			if (sel_mask_high)
				ref_fail_mask_high_pair <= wr_data;
			if (sel_cfg)
				ref_input_config <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			raw_fail_low <= 8'h00;
			raw_fail_high <= 8'h00;
			ref_fail_status <= 4'h0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			raw_fail_low <= next_raw_low;
			raw_fail_high <= next_raw_high;
			ref_fail_status <= next_status;
			rd_valid <= rd_en;
			if (rd_en)
				rd_data <= next_rd_data;
		end
	end

	// ****************************************
	// input paths
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_path
			rfm_input_path u_path (
				.clk(clk),
				.srst(srst),
				.positive_pin(input_positive_pin[gi]),
				.negative_pin(input_negative_pin[gi]),
				.halve_enable(input_halve_enable[gi]),
				.differential_select(input_differential_select[gi]),
				.loop_ref(loop_ref[gi])
			);
		end
	endgenerate

	// ****************************************
	// checks
	// ****************************************
	a_gate_layout: assert property (@(posedge clk) disable iff (srst)
		scm_event[0] && !srst ##1 1'b1 |-> raw_fail_low[`RFM_BIT_SCM])
		else $error("single-cycle failure not at bit 1");
	a_mask_hides: assert property (@(posedge clk) disable iff (srst)
		ref_fail_mask_low_pair[3:0] == 4'h0 ##1 ref_fail_mask_low_pair[3:0] == 4'h0
		|-> !ref_fail_status[0])
		else $error("masked reference 0 shows in status");
	a_raw_unmasked: assert property (@(posedge clk) disable iff (srst)
		los_event[2] |=> raw_fail_high[`RFM_BIT_LOS])
		else $error("raw loss bit not recorded");
	a_high_nibble: assert property (@(posedge clk) disable iff (srst)
		wr_en && sel_mask_low |=> gate1 == $past(wr_data[7:4]))
		else $error("reference 1 gate not in upper nibble");
	a_halve_map: assert property (@(posedge clk) disable iff (srst)
		wr_en && sel_cfg |=> input_halve_enable == $past(wr_data[3:0]))
		else $error("halve enables misplaced");
	a_diff_map: assert property (@(posedge clk) disable iff (srst)
		wr_en && sel_cfg |=> input_differential_select == $past(wr_data[7:4]))
		else $error("differential selects misplaced");
	a_sticky_hold: assert property (@(posedge clk) disable iff (srst)
		raw_fail_low[`RFM_BIT_SCM] && !(wr_en && sel_raw_low) |=> raw_fail_low[`RFM_BIT_SCM])
		else $error("sticky bit lost without clear");
	a_status_or: assert property (@(posedge clk) disable iff (srst)
		!$past(srst) |-> ref_fail_status[3] == |($past(raw_fail_high[7:4]) & $past(gate3)))
		else $error("status is not gated OR");

	// ****************************************
	// status, raw and register checks
	// ****************************************
	a_status_ref0: assert property (@(posedge clk) disable iff (srst)
		!$past(srst) |-> ref_fail_status[0] == |($past(raw_fail_low[3:0]) & $past(gate0)))
		else $error("reference 0 status is not gated OR");
	a_status_ref1: assert property (@(posedge clk) disable iff (srst)
		!$past(srst) |-> ref_fail_status[1] == |($past(raw_fail_low[7:4]) & $past(gate1)))
		else $error("reference 1 status is not gated OR");
	a_status_ref2: assert property (@(posedge clk) disable iff (srst)
		!$past(srst) |-> ref_fail_status[2] == |($past(raw_fail_high[3:0]) & $past(gate2)))
		else $error("reference 2 status is not gated OR");
	a_raw_ref0_sets: assert property (@(posedge clk) disable iff (srst)
		los_event[0] || scm_event[0] || cfm_event[0] || gst_event[0] |=>
		raw_fail_low[`RFM_BIT_LOS] >= $past(los_event[0])
		&& raw_fail_low[`RFM_BIT_SCM] >= $past(scm_event[0])
		&& raw_fail_low[`RFM_BIT_CFM] >= $past(cfm_event[0])
		&& raw_fail_low[`RFM_BIT_GST] >= $past(gst_event[0]))
		else $error("reference 0 raw failure not recorded");
	a_raw_ref3_sets: assert property (@(posedge clk) disable iff (srst)
		los_event[3] || scm_event[3] || cfm_event[3] || gst_event[3] |=>
		raw_fail_high[4 + `RFM_BIT_LOS] >= $past(los_event[3])
		&& raw_fail_high[4 + `RFM_BIT_SCM] >= $past(scm_event[3])
		&& raw_fail_high[4 + `RFM_BIT_CFM] >= $past(cfm_event[3])
		&& raw_fail_high[4 + `RFM_BIT_GST] >= $past(gst_event[3]))
		else $error("reference 3 raw failure not recorded");
	a_raw_low_keeps: assert property (@(posedge clk) disable iff (srst)
		!(wr_en && sel_raw_low) |=>
		(raw_fail_low & $past(raw_fail_low)) == $past(raw_fail_low))
		else $error("low raw pair dropped a bit");
	a_raw_high_keeps: assert property (@(posedge clk) disable iff (srst)
		!(wr_en && sel_raw_high) |=>
		(raw_fail_high & $past(raw_fail_high)) == $past(raw_fail_high))
		else $error("high raw pair dropped a bit");
	a_low_pair_write: assert property (@(posedge clk) disable iff (srst)
		wr_en && sel_mask_low |=> ref_fail_mask_low_pair == $past(wr_data))
		else $error("low gate pair not written");
	a_high_pair_write: assert property (@(posedge clk) disable iff (srst)
		wr_en && sel_mask_high |=> ref_fail_mask_high_pair == $past(wr_data))
		else $error("high gate pair not written");
	a_gate_high_hold: assert property (@(posedge clk) disable iff (srst)
		!(wr_en && sel_mask_high) |=> $stable(ref_fail_mask_high_pair))
		else $error("high gate pair changed without write");
	a_cfg_hold: assert property (@(posedge clk) disable iff (srst)
		!(wr_en && sel_cfg) |=> $stable(ref_input_config))
		else $error("input config changed without write");
	a_isr_read: assert property (@(posedge clk) disable iff (srst)
		rd_en && sel_isr |=> rd_data == {4'h0, $past(ref_fail_status)})
		else $error("interrupt status read wrong");
	c_status_hidden: cover property (@(posedge clk) gate0 == 4'h0 && raw_fail_low[3:0] != 4'h0);
	c_fail_seen: cover property (@(posedge clk) ref_fail_status[0]);
	c_fail_masked: cover property (@(posedge clk) raw_fail_low[0] && !ref_fail_status[0]);
	c_halved: cover property (@(posedge clk) input_halve_enable[0] && loop_ref[0]);
	c_clear: cover property (@(posedge clk) wr_en && sel_raw_low && raw_fail_low != 8'h00);
endmodule // rfm_bank

/* File: test/rfm_host_model.sv */
// host model driving the register port of the reference bank
`timescale 1ns/1ps
module rfm_host_model (
	// clock
	input wire logic clk,
	// register port
	output logic wr_en,
	output logic rd_en,
	output logic [6:0] addr,
	output logic [7:0] wr_data
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 7'h00;
		wr_data = 8'h00;
	end
	// one write, strobe high one cycle, then strobe dropped and address and data driven inverted
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		addr <= ~a;
		wr_data <= ~d;
	endtask
	// one read strobe
	task automatic rd(input logic [6:0] a);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		addr <= ~a;
	endtask
endmodule // rfm_host_model

/* File: test/test_rfm_bank.sv */
// self-checking bench for the reference mask and input config bank
`timescale 1ns/1ps
module test_rfm_bank
	import rfm_pkg::*;
;
	// ***************
	// signals
	// ***************
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic wr_en, rd_en, rd_valid, pins_same = 1'b0;
	logic [6:0] addr;
	logic [7:0] wr_data, rd_data;
	logic [3:0] ev[4] = '{4'h0, 4'h0, 4'h0, 4'h0};
	logic [3:0] pin_p = 4'h0, pin_n = 4'hF;
	logic [3:0] loop_ref, status, halve, diff;
	logic [3:0] lr_prev;
	rfm_gate_t g;
	rfm_byte_t cfg;
	rfm_byte_t exp_q[$];
	rfm_byte_t lcfg[4] = '{8'h00, 8'h0F, 8'hF0, 8'hF0};
	// halved inputs counted at half rate
	int lexp[4] = '{20, 10, 20, 0};
	logic lsame[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
	int num_errors = 0;
	int tests_run = 0;
	int seed = 44;
	int edges[4] = '{0, 0, 0, 0};
	int e0[4];
	initial begin
		forever #50 clk = ~clk;
	end
	rfm_host_model i_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data));
	rfm_bank i_dut (.clk(clk), .srst(srst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .los_event(ev[0]),
		.scm_event(ev[1]), .cfm_event(ev[2]), .gst_event(ev[3]),
		.input_positive_pin(pin_p), .input_negative_pin(pin_n), .loop_ref(loop_ref),
		.ref_fail_status(status), .input_halve_enable(halve),
		.input_differential_select(diff));
	// ***************
	// pins, edge count, read monitor
	// ***************
	always @(posedge clk) begin
		pin_p <= ~pin_p;
		pin_n <= pins_same ? ~pin_p : pin_p;
		lr_prev <= loop_ref;
		if (loop_ref[0] && !lr_prev[0]) edges[0] <= edges[0] + 1;
		if (loop_ref[1] && !lr_prev[1]) edges[1] <= edges[1] + 1;
		if (loop_ref[2] && !lr_prev[2]) edges[2] <= edges[2] + 1;
		if (loop_ref[3] && !lr_prev[3]) edges[3] <= edges[3] + 1;
		if (rd_valid === 1'b1) chk(rd_data, exp_q.pop_front());
	end
	task automatic chk(input rfm_byte_t got, input rfm_byte_t exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_status(input logic [3:0] exp);
		chk(8'(status), 8'(exp));
	endtask
	task automatic chk_cfg(input rfm_byte_t exp);
		chk({diff, halve}, exp);
	endtask
	task automatic chk_edges(input int got, input int exp);
		chk(8'(got), 8'(exp));
	endtask
	task automatic rd(input logic [6:0] a, input rfm_byte_t e);
		exp_q.push_back(e);
		i_host.rd(a);
	endtask
	task automatic end_sim;
		$display("counts: %0d compared, %0d wrong", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ***************
	// tests
	// ***************
	initial begin
		#300000;
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rd(7'h09, 8'h66);
		rd(7'h08, 8'h66);
		rd(7'h0A, 8'h10);
		rd(7'h07, 8'h00);
		rd(7'h7F, 8'h00);
		i_host.wr(7'h02, 8'hFF);
		rd(7'h02, 8'h00);
		cfg = 8'($random(seed));
		i_host.wr(7'h0A, cfg);
		rd(7'h0A, cfg);
		chk_cfg(cfg);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			pins_same <= lsame[i];
			i_host.wr(7'h0A, lcfg[i]);
			repeat (8) @(posedge clk);
			e0 = edges;
			repeat (40) @(posedge clk);
			for (int j = 0; j < 4; j++) begin
				chk_edges(edges[j] - e0[j], lexp[i]);
			end
		end
		$display("test input path done");
		for (int k = 0; k < 4; k++) begin
			g = 4'(1 << k);
			i_host.wr(7'h07, 8'hFF);
			i_host.wr(7'h06, 8'hFF);
			i_host.wr(7'h09, {~g, g});
			i_host.wr(7'h08, {~g, g});
			ev[k] <= 4'hF;
			@(posedge clk);
			ev[k] <= 4'h0;
			repeat (2) @(posedge clk);
			chk_status(4'h5);
			rd(7'h02, 8'h05);
			rd(7'h07, {g, g});
			rd(7'h06, {g, g});
		end
		i_host.wr(7'h09, 8'h00);
		ev[0] <= 4'hF;
		@(posedge clk);
		ev[0] <= 4'h0;
		repeat (2) @(posedge clk);
		chk_status(4'hC);
		rd(7'h07, 8'h99);
		rd(7'h02, 8'h0C);
		$display("test failure gating done");
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		chk_status(4'h0);
		rd(7'h09, 8'h66);
		rd(7'h07, 8'h00);
		rd(7'h0A, 8'h10);
		repeat (2) @(posedge clk);
		chk(8'(exp_q.size()), 8'h00);
		$display("test reset done");
		end_sim();
	end
endmodule // test_rfm_bank
